// ---- inc/exec_pkg.sv ----
// execution datapath package: operation codes, flag layout, cycle counts, carriers
// assumes an 8-bit core with a 16-bit program counter and external register file
package exec_pkg;
    typedef enum logic [5:0] {
        op_nop, op_add, op_add_carry, op_word_add_immediate, op_sub, op_minus_constant,
        op_minus_with_borrow, op_minus_constant_borrow, op_word_minus_immediate,
        op_and, op_and_constant, op_or, op_or_constant, op_xor_registers, op_ones_complement,
        op_zero_minus_reg, op_set_bits_mask, op_clear_bits_mask, op_increment, op_minus_one,
        op_zero_minus_check, op_zero_register, op_all_ones_load, op_relative_jump,
        op_indirect_jump, op_relative_call, op_indirect_call, op_subroutine_exit,
        op_interrupt_exit, op_equal_skip, op_compare, op_compare_borrow, op_compare_immediate,
        op_skip_bit_low
    } op_type;

    // status register bit positions
    localparam int flag_c = 0;
    localparam int flag_z = 1;
    localparam int flag_n = 2;
    localparam int flag_v = 3;
    localparam int flag_s = 4;
    localparam int flag_h = 5;
    localparam int flag_t = 6;
    localparam int flag_i = 7;

    localparam logic [7:0] all_ones = 8'hff;
    localparam logic [7:0] all_zero = 8'h00;
    localparam logic [15:0] pc_reset = 16'h0000;
    localparam logic [7:0] sreg_reset = 8'h00;

    // cycle counts per instruction class
    localparam logic [2:0] cycles_alu = 3'h1;
    localparam logic [2:0] cycles_word = 3'h2;
    localparam logic [2:0] cycles_jump = 3'h2;
    localparam logic [2:0] cycles_call = 3'h3;
    localparam logic [2:0] cycles_return = 3'h4;
    localparam logic [2:0] cycles_no_skip = 3'h1;
    localparam logic [2:0] cycles_skip_one = 3'h2;
    localparam logic [2:0] cycles_skip_two = 3'h3;
    localparam logic [15:0] pc_step = 16'h0001;
    localparam logic [15:0] skip_one = 16'h0002;
    localparam logic [15:0] skip_two = 16'h0003;

    // one instruction as issued by the decoder
    typedef struct packed {
        op_type op;
        logic [7:0] dst;           // destination or low word register
        logic [7:0] dst_high;      // high register of a word pair
        logic [7:0] src;           // source register
        logic [7:0] konst;         // immediate constant or mask
        logic [11:0] offset;       // signed relative offset
        logic [2:0] bit_sel;       // bit number for bit skips
        logic next_two_word;       // instruction after this one is two words
    } instr_type;

    // register file write-back
    typedef struct packed {
        logic write;
        logic word;
        logic [7:0] low;
        logic [7:0] high;
    } result_type;

    // stack access request
    typedef struct packed {
        logic push;
        logic pop;
        logic [15:0] data;
    } stack_type;
endpackage

// ---- rtl/alu_core.sv ----
// combinational 8/16-bit arithmetic and flag unit
// assumes operands already selected by the sequencer
`timescale 1ns/10ps
`default_nettype none
module alu_core
    import exec_pkg::*;
(
    // operation and operands
    input wire exec_pkg::op_type op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic [7:0] a_high,
    input wire logic [7:0] flags_in,
    // results
    output logic [7:0] res,
    output logic [7:0] res_high,
    output logic [7:0] flags_out,
    output logic store
);
    logic [8:0] wide;
    logic [16:0] word;
    logic [7:0] r;
    logic cin;
    logic is_sub;
    logic half;

    ///////////////////////////////////////////////////////////////////////////
    // value and flags; unused flags pass through unchanged
    always_comb begin
        flags_out = flags_in;
        res_high = a_high;
        store = 1'b1;
        cin = flags_in[flag_c];
        wide = 9'h000;
        word = 17'h00000;
        is_sub = 1'b0;
        half = 1'b0;
        r = a;
        case (op)
            op_add, op_add_carry: begin
                wide = {1'b0, a} + {1'b0, b} + {8'h00, (op == op_add_carry) & cin}; // see (RL1)
                half = (a[3] & b[3]) | (b[3] & ~wide[3]) | (~wide[3] & a[3]);
                r = wide[7:0];
                flags_out[flag_c] = wide[8];
                flags_out[flag_v] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
                flags_out[flag_h] = half;
            end
            op_sub, op_minus_constant, op_minus_with_borrow, op_minus_constant_borrow, op_zero_minus_reg,
            op_compare, op_compare_borrow, op_compare_immediate: begin
                is_sub = (op == op_minus_with_borrow) | (op == op_minus_constant_borrow) | (op == op_compare_borrow);
                wide = {1'b0, a} - {1'b0, b} - {8'h00, is_sub & cin}; // see (RL3) see (RL4) see (RL8)
                r = wide[7:0];
                half = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
                flags_out[flag_c] = wide[8];
                flags_out[flag_v] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
                flags_out[flag_h] = half;
                store = (op != op_compare) & (op != op_compare_borrow) & (op != op_compare_immediate); // see (RL16)
            end
            op_word_add_immediate, op_word_minus_immediate: begin
                if (op == op_word_add_immediate) begin
                    word = {1'b0, a_high, a} + {9'h000, b}; // see (RL2)
                    flags_out[flag_v] = ~a_high[7] & word[15];
                end else begin
                    word = {1'b0, a_high, a} - {9'h000, b}; // see (RL5)
                    flags_out[flag_v] = a_high[7] & ~word[15];
                end
                r = word[7:0];
                res_high = word[15:8];
                flags_out[flag_c] = word[16];
            end
            op_and, op_and_constant, op_zero_minus_check: r = a & b; // see (RL6) see (RL11)
            op_or, op_or_constant, op_set_bits_mask: r = a | b; // see (RL7) see (RL9)
            op_xor_registers, op_zero_register: r = a ^ b; // see (RL12)
            op_clear_bits_mask: r = a & (all_ones - b); // see (RL9)
            op_ones_complement: begin
                r = all_ones - a; // see (RL8)
                flags_out[flag_c] = 1'b1;
            end
            op_increment: r = a + 8'h01; // see (RL10)
            op_minus_one: r = a - 8'h01;
            op_all_ones_load: r = all_ones; // see (RL12)
            default: store = 1'b0;
        endcase
        // logic, complement and step ops share the simpler overflow rules
        if (op inside {op_and, op_and_constant, op_zero_minus_check, op_or, op_or_constant, op_set_bits_mask,
                       op_xor_registers, op_zero_register, op_clear_bits_mask, op_ones_complement})
            flags_out[flag_v] = 1'b0;
        if (op == op_increment)
            flags_out[flag_v] = (r == 8'h80);
        if (op == op_minus_one)
            flags_out[flag_v] = (r == 8'h7f);
        if (op inside {op_word_add_immediate, op_word_minus_immediate}) begin
            flags_out[flag_z] = ({res_high, r} == 16'h0000);
            flags_out[flag_n] = res_high[7];
        end else if (store || !(op inside {op_nop, op_all_ones_load})) begin
            flags_out[flag_z] = (r == all_zero);
            flags_out[flag_n] = r[7];
        end
        if (op == op_all_ones_load || !(store || op inside {op_compare, op_compare_borrow, op_compare_immediate}))
            flags_out = flags_in;
        else
            flags_out[flag_s] = flags_out[flag_n] ^ flags_out[flag_v];
        res = r;
    end
endmodule
`default_nettype wire

// ---- rtl/exec_datapath.sv ----
// execution datapath: arithmetic, logic, jumps, calls, returns and skips
// assumes the decoder holds issue high for one cycle per instruction and waits for done
// How it works
// (RL1) add registers, optional carry, one cycle
// (RL2) word add immediate on pair, two cycles
// (RL3) subtract register or constant, one cycle
// (RL4) subtract with borrow also subtracts carry
// (RL5) word subtract immediate on pair, two cycles
// (RL6) and keeps carry, sets z n v
// (RL7) or and xor set z n v
// (RL8) complement ff minus, negate zero minus
// (RL9) set bits or mask, clear bits and
// (RL10) increment decrement leave carry alone
// (RL11) test ands register with itself
// (RL12) clear xors itself, all-ones load flagless
// (RL13) jumps: pc plus offset plus one, or z
// (RL14) calls form target like jumps, three cycles
// (RL15) equal skip takes one, two or three
// (RL16) compares subtract without storing result
// (RL17) skip on cleared bit, one-two-three cycles
// (RL18) returns pop pc in four cycles
// (RL19) skip costs by skipped instruction length
`timescale 1ns/10ps
`default_nettype none
module exec_datapath
    import exec_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // instruction issue
    input wire logic issue,
    input wire exec_pkg::instr_type instr,
    input wire logic [15:0] z_pointer,
    // stack data returned for pops
    input wire logic [15:0] stack_read,
    // results
    output logic busy,
    output logic done,
    output exec_pkg::result_type result,
    output exec_pkg::stack_type stack,
    output logic [15:0] pc,
    output logic [7:0] sreg,
    output logic interrupt_enable_set
);
    import exec_pkg::*;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_wait = 2'b01,
        st_last = 2'b11
    } state_type;

    state_type state, next_state;
    logic [2:0] count, next_count;
    logic [15:0] next_pc;
    logic [7:0] next_sreg;
    result_type next_result;
    stack_type next_stack;
    logic next_done;
    logic next_ie;
    instr_type held, next_held;
    logic [15:0] target, next_target;

    logic [7:0] alu_b;
    logic [7:0] alu_res;
    logic [7:0] alu_res_high;
    logic [7:0] alu_flags;
    logic alu_store;
    logic [15:0] rel_target;
    logic [2:0] skip_cycles;
    logic skip_taken;
    logic [15:0] skip_pc;

    ///////////////////////////////////////////////////////////////////////////
    // operand b select: constants, masks, or self for test and clear
    always_comb begin
        case (instr.op)
            op_word_add_immediate, op_word_minus_immediate, op_minus_constant, op_minus_constant_borrow,
            op_and_constant, op_or_constant, op_set_bits_mask, op_clear_bits_mask,
            op_compare_immediate: alu_b = instr.konst;
            op_zero_minus_check, op_zero_register: alu_b = instr.dst; // see (RL11) see (RL12)
            default: alu_b = instr.src;
        endcase
    end

    // negate is zero minus the register, so the register becomes operand b
    alu_core u_alu (
        .op(instr.op),
        .a((instr.op == op_zero_minus_reg) ? all_zero : instr.dst),
        .b((instr.op == op_zero_minus_reg) ? instr.dst : alu_b),
        .a_high(instr.dst_high),
        .flags_in(sreg),
        .res(alu_res),
        .res_high(alu_res_high),
        .flags_out(alu_flags),
        .store(alu_store)
    );

    ///////////////////////////////////////////////////////////////////////////
    // branch targets and skip decision
    always_comb begin
        rel_target = pc + {{4{instr.offset[11]}}, instr.offset} + pc_step; // see (RL13)
        case (instr.op)
            op_equal_skip: skip_taken = (instr.dst == instr.src); // see (RL15)
            op_skip_bit_low: skip_taken = ~instr.dst[instr.bit_sel]; // see (RL17)
            default: skip_taken = 1'b0;
        endcase
        // a skip over a two-word instruction must also step over its second word, costing one more cycle
        if (!skip_taken) begin
            skip_cycles = cycles_no_skip;
            skip_pc = pc_step;
        end else if (instr.next_two_word) begin
            skip_cycles = cycles_skip_two; // see (RL19)
            skip_pc = skip_two;
        end else begin
            skip_cycles = cycles_skip_one; // see (RL19)
            skip_pc = skip_one;
        end
    end

    ///////////////////////////////////////////////////////////////////////////
    // sequencer: single-cycle ops finish at issue, multi-cycle ops count down
    always_comb begin
        next_state = state;
        next_count = count;
        next_pc = pc;
        next_sreg = sreg;
        next_result = '0;
        next_stack = '0;
        next_done = 1'b0;
        next_ie = 1'b0;
        next_held = held;
        next_target = target;
        case (state)
            st_idle: begin
                if (issue) begin
                    next_held = instr;
                    case (instr.op)
                        op_word_add_immediate, op_word_minus_immediate: begin
                            next_count = cycles_word - 3'h1; // see (RL2) see (RL5)
                            next_state = st_last;
                        end
                        op_relative_jump, op_indirect_jump: begin
                            next_target = (instr.op == op_relative_jump) ? rel_target : z_pointer; // see (RL13)
                            next_count = cycles_jump - 3'h1;
                            next_state = st_last;
                        end
                        op_relative_call, op_indirect_call: begin
                            next_target = (instr.op == op_relative_call) ? rel_target : z_pointer; // see (RL14)
                            next_stack.push = 1'b1; // see (RL18)
                            next_stack.data = pc + pc_step;
                            next_count = cycles_call - 3'h1;
                            next_state = st_wait;
                        end
                        op_subroutine_exit, op_interrupt_exit: begin
                            next_stack.pop = 1'b1; // see (RL18)
                            next_count = cycles_return - 3'h1;
                            next_state = st_wait;
                        end
                        op_equal_skip, op_skip_bit_low: begin
                            next_target = pc + skip_pc; // see (RL15) see (RL17)
                            next_count = skip_cycles - 3'h1;
                            if (skip_cycles == cycles_no_skip) begin
                                next_pc = next_target;
                                next_done = 1'b1;
                            end else begin
                                next_state = (skip_cycles == cycles_skip_one) ? st_last : st_wait;
                            end
                        end
                        default: begin
                            // one-cycle arithmetic and logic
                            next_result.write = alu_store; // see (RL1) see (RL3) see (RL4)
                            next_result.low = alu_res;
                            next_sreg = alu_flags; // see (RL6) see (RL7) see (RL10) see (RL16)
                            next_pc = pc + pc_step;
                            next_done = 1'b1;
                        end
                    endcase
                end
            end
            st_wait: begin
                // returns sample stack data once the pop has landed
                if (held.op inside {op_subroutine_exit, op_interrupt_exit})
                    next_target = stack_read;
                next_count = count - 3'h1;
                if (count == 3'h2)
                    next_state = st_last;
            end
            st_last: begin
                next_state = st_idle;
                next_done = 1'b1;
                next_count = 3'h0;
                if (held.op inside {op_word_add_immediate, op_word_minus_immediate}) begin
                    // word result written at the end so the pair updates together
                    next_result.write = 1'b1;
                    next_result.word = 1'b1;
                    next_result.low = alu_res;
                    next_result.high = alu_res_high;
                    next_sreg = alu_flags;
                    next_pc = pc + pc_step;
                end else begin
                    next_pc = target;
                    next_ie = (held.op == op_interrupt_exit);
                    if (held.op == op_interrupt_exit)
                        next_sreg[flag_i] = 1'b1;
                end
            end
            default: next_state = st_idle;
        endcase
    end

    // decoder keeps instr stable while busy, so the alu sees the word operands in st_last
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= st_idle;
            count <= 3'h0;
            pc <= pc_reset;
            sreg <= sreg_reset;
            result <= '0;
            stack <= '0;
            done <= 1'b0;
            interrupt_enable_set <= 1'b0;
            held <= '0;
            target <= pc_reset;
        end else begin
            state <= next_state;
            count <= next_count;
            pc <= next_pc;
            sreg <= next_sreg;
            result <= next_result;
            stack <= next_stack;
            done <= next_done;
            interrupt_enable_set <= next_ie;
            held <= next_held;
            target <= next_target;
        end
    end

    assign busy = (state != st_idle);
endmodule
`default_nettype wire

// ---- verif/exec_chk.sv ----
// checker for the execution datapath: cycle counts, stack pulses, pc and flag steadiness
// assumes it is bound to exec_datapath and sees only that module's ports
`timescale 1ns/10ps
`default_nettype none
module exec_chk
    import exec_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // instruction side
    input wire logic issue,
    input wire exec_pkg::instr_type instr,
    input wire logic [15:0] z_pointer,
    input wire logic [15:0] stack_read,
    // results
    input wire logic busy,
    input wire logic done,
    input wire exec_pkg::result_type result,
    input wire exec_pkg::stack_type stack,
    input wire logic [15:0] pc,
    input wire logic [7:0] sreg,
    input wire logic interrupt_enable_set
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic take;
    // an issue only counts while the datapath is idle
    assign take = issue && !busy;
    ////////////////////////////////////////////////////////////////////////
    // arithmetic and logic answers
    a_add_sum: assert property (
        take && instr.op == op_add |=> done && result.write && result.low == 8'($past(instr.dst) + $past(instr.src)))
        else $error("register add result or timing wrong");
    a_word_two: assert property (
        take && instr.op inside {op_word_add_immediate, op_word_minus_immediate} |=> !done ##1 (done && result.word))
        else $error("word operation not done in two cycles");
    a_and_carry: assert property (
        take && instr.op inside {op_and, op_and_constant} |=> done && $stable(sreg[flag_c]))
        else $error("and changed the carry flag");
    a_compare_nowrite: assert property (
        take && instr.op inside {op_compare, op_compare_borrow, op_compare_immediate} |=> done && !result.write)
        else $error("compare stored a result");
    a_ones_load: assert property (
        take && instr.op == op_all_ones_load |=> done && result.low == all_ones && $stable(sreg))
        else $error("all ones load wrong or touched flags");
    ////////////////////////////////////////////////////////////////////////
    // program flow
    a_jump_target: assert property (
        take && instr.op == op_indirect_jump |=> !done ##1 (done && pc == $past(z_pointer, 2)))
        else $error("indirect jump target or timing wrong");
    a_call_push: assert property (
        take && instr.op inside {op_relative_call, op_indirect_call}
        |=> stack.push && stack.data == $past(pc) + pc_step ##1 !done ##1 done)
        else $error("call push or timing wrong");
    a_return_pop: assert property (
        take && instr.op inside {op_subroutine_exit, op_interrupt_exit} |=> stack.pop ##1 !done [*2] ##1 done)
        else $error("return pop or timing wrong");
    a_pc_steady: assert property (
        !done |-> $stable(pc))
        else $error("pc moved without done");
    a_ie_done: assert property (
        interrupt_enable_set |-> done && sreg[flag_i])
        else $error("interrupt enable pulse out of place");
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench for exec_datapath: random instructions against a behavioural model
// assumes instr held until done; the bench plays decoder and stack
`timescale 1ns/10ps
`default_nettype none
module tb;
    import exec_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic issue = 1'b0;
    instr_type instr = '0;
    logic [15:0] z_pointer = 16'h0000;
    logic [15:0] stack_read = 16'h0000;
    logic busy, done, interrupt_enable_set;
    result_type result;
    stack_type stack;
    logic [15:0] pc, e_pc;
    logic [7:0] sreg, e_sreg;
    int mismatches = 0;
    int cmp_count = 0;
    int ticks = 0;

    always #25 sys_clk = ~sys_clk;

    exec_datapath u_exec_datapath (.sys_clk(sys_clk), .reset(reset), .issue(issue), .instr(instr),
        .z_pointer(z_pointer), .stack_read(stack_read), .busy(busy), .done(done), .result(result),
        .stack(stack), .pc(pc), .sreg(sreg), .interrupt_enable_set(interrupt_enable_set));
    ////////////////////////////////////////////////////////////////////////
    // reporting
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ceiling far above the thousand or so cycles of the run
    always @(posedge sys_clk) begin
        ticks++;
        if (ticks == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // flag model: mode 0 add, 1 subtract, 2 logic; m picks the flags that change
    function automatic logic [7:0] fl(input logic [7:0] f, a, b, r, input logic [1:0] mode, input logic [7:0] m);
        logic [7:0] t, x, y;
        x = (mode == 2'd1) ? ~a : a; // subtract borrows are add carries on inverted operands
        y = (mode == 2'd1) ? ~r : r;
        t = f;
        t[flag_c] = x[7] & b[7] | b[7] & ~y[7] | ~y[7] & x[7];
        t[flag_h] = x[3] & b[3] | b[3] & ~y[3] | ~y[3] & x[3];
        t[flag_v] = (mode != 2'd2) & (x[7] & b[7] & ~y[7] | ~x[7] & ~b[7] & y[7]);
        t[flag_n] = r[7];
        t[flag_z] = (r == 8'h00);
        t[flag_s] = t[flag_n] ^ t[flag_v];
        return (f & ~m) | (t & m);
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // one instruction: model, issue, wait for done, compare; issue stays high
    task automatic run(input instr_type i);
        logic [7:0] a, b, r, ef, cc, m;
        logic [15:0] w, ep, pdata;
        logic [2:0] cyc;
        logic [1:0] md;
        logic wr, wd, ie, p, q, add;
        int n, pushes, pops;
        a = i.dst;
        b = (i.op == op_zero_minus_check) ? a : i.src;
        if (i.op inside {op_minus_constant, op_minus_constant_borrow, op_and_constant, op_or_constant,
            op_set_bits_mask, op_compare_immediate}) b = i.konst;
        cc = {7'h00, e_sreg[flag_c]};
        {ef, ep, cyc, wr, wd, ie, md, m, r, w} = {e_sreg, e_pc + pc_step, cycles_alu, 3'b100, 2'd2, 8'h1e, a, 16'h0000};
        add = (i.op == op_word_add_immediate);
        case (i.op)
            op_add: {r, md, m} = {a + b, 2'd0, 8'h3f};
            op_add_carry: {r, md, m} = {a + b + cc, 2'd0, 8'h3f};
            op_sub, op_minus_constant: {r, md, m} = {a - b, 2'd1, 8'h3f};
            op_minus_with_borrow, op_minus_constant_borrow: {r, md, m} = {a - b - cc, 2'd1, 8'h3f};
            op_compare, op_compare_immediate: {r, md, m, wr} = {a - b, 2'd1, 8'h3f, 1'b0};
            op_compare_borrow: {r, md, m, wr} = {a - b - cc, 2'd1, 8'h3f, 1'b0};
            op_and, op_and_constant, op_zero_minus_check: r = a & b;
            op_or, op_or_constant, op_set_bits_mask: r = a | b;
            op_xor_registers: r = a ^ b;
            op_clear_bits_mask: r = a & (all_ones - i.konst);
            op_ones_complement: r = all_ones - a;
            op_zero_minus_reg: {r, a, b, md, m} = {all_zero - a, all_zero, a, 2'd1, 8'h3f};
            op_increment: {r, b, md} = {a + 8'h01, 8'h01, 2'd0};
            op_minus_one: {r, b, md} = {a - 8'h01, 8'h01, 2'd1};
            op_zero_register: r = all_zero;
            op_all_ones_load: {r, m} = {all_ones, 8'h00};
            op_word_add_immediate, op_word_minus_immediate: begin
                w = add ? {i.dst_high, a} + {8'h00, i.konst} : {i.dst_high, a} - {8'h00, i.konst};
                {cyc, wd, m} = {cycles_word, 1'b1, 8'h00};
            end
            op_relative_jump, op_relative_call: ep = e_pc + {{4{i.offset[11]}}, i.offset} + pc_step;
            op_indirect_jump, op_indirect_call: ep = z_pointer;
            op_subroutine_exit, op_interrupt_exit: ep = stack_read;
            op_equal_skip, op_skip_bit_low:
                if (i.op == op_equal_skip ? a == b : !a[i.bit_sel]) {ep, cyc} = i.next_two_word ?
                    {e_pc + skip_two, cycles_skip_two} : {e_pc + skip_one, cycles_skip_one};
            default: m = 8'h00;
        endcase
        if (i.op inside {op_relative_jump, op_indirect_jump, op_relative_call, op_indirect_call, op_subroutine_exit,
            op_interrupt_exit, op_equal_skip, op_skip_bit_low}) {wr, m} = 9'h000;
        if (i.op inside {op_relative_jump, op_indirect_jump}) cyc = cycles_jump;
        if (i.op inside {op_relative_call, op_indirect_call}) cyc = cycles_call;
        if (i.op inside {op_subroutine_exit, op_interrupt_exit}) cyc = cycles_return;
        ef = fl(ef, a, b, r, md, m);
        if (i.op == op_ones_complement) ef[flag_c] = 1'b1;
        {p, q} = {~i.dst_high[7] & w[15], i.dst_high[7] & ~w[15]};
        if (wd) ef[5:0] = {ef[flag_h], (w[15] ^ (add ? p : q)), (add ? p : q), w[15], (w == 16'h0000), (add ? q : p)};
        if (i.op == op_interrupt_exit) {ef[flag_i], ie} = 2'b11;
        instr = i;
        issue = 1'b1;
        @(posedge sys_clk);
        #2;
        {pushes, pops, pdata} = {32'd0, 32'd0, 16'h0000};
        for (n = 1; done !== 1'b1 && n < 8; n++) begin
            pushes += int'(stack.push);
            pops += int'(stack.pop);
            if (stack.push === 1'b1) pdata = stack.data;
            @(posedge sys_clk);
            #2;
        end
        check("cycles", 16'(n), {13'h0000, cyc});
        check("pc", pc, ep);
        check("sreg", {8'h00, sreg}, {8'h00, ef});
        check("write", {14'h0000, result.word, result.write}, {14'h0000, wd, wr});
        if (wr) check("data", {wd ? result.high : 8'h00, result.low}, wd ? w : {8'h00, r});
        check("push", 16'(pushes), {15'h0000, i.op inside {op_relative_call, op_indirect_call}});
        if (pushes == 1) check("push data", pdata, e_pc + pc_step);
        check("pop", 16'(pops), {15'h0000, i.op inside {op_subroutine_exit, op_interrupt_exit}});
        check("ie busy", {14'h0000, busy, interrupt_enable_set}, {14'h0000, 1'b0, ie});
        {e_pc, e_sreg} = {ep, ef};
    endtask

    task automatic do_reset(input int len);
        issue = 1'b0;
        reset = 1'b1;
        repeat (len) @(posedge sys_clk);
        #2;
        reset = 1'b0;
        {e_pc, e_sreg} = {pc_reset, sreg_reset};
        check("reset pc", pc, pc_reset);
        check("reset sreg", {8'h00, sreg}, {8'h00, sreg_reset});
    endtask
    ////////////////////////////////////////////////////////////////////////
    // random instruction stream, back to back or with idle gaps, and a reset in mid-run
    initial begin
        instr_type i;
        int k;
        k = $urandom(69);
        do_reset(20);
        for (k = 0; k < 600; k++) begin
            i = instr_type'(54'({$urandom, $urandom}));
            i.op = op_type'(6'($urandom_range(33, 1)));
            if (i.op == op_skip_bit_low || (k % 2 == 0 && i.op == op_equal_skip)) i.src = i.dst;
            z_pointer = 16'($urandom);
            stack_read = 16'($urandom);
            run(i);
            if ($urandom_range(3, 0) == 0) begin
                issue = 1'b0;
                @(posedge sys_clk);
                #2;
            end
            if (k == 300) do_reset(2);
        end
        finish_test();
    end
endmodule

bind exec_datapath exec_chk u_chk (.sys_clk(sys_clk), .reset(reset), .issue(issue), .instr(instr),
    .z_pointer(z_pointer), .stack_read(stack_read), .busy(busy), .done(done), .result(result),
    .stack(stack), .pc(pc), .sreg(sreg), .interrupt_enable_set(interrupt_enable_set));
`default_nettype wire
